/* File: pzs_sram.sv */
// module: pipelined zero-turnaround sram with four-word burst counter
//
// Summary of operation
// [RQ1] - data of a load or burst step moves on the bus two edges later
// [RQ2] - clock enable high freezes all pipeline, burst and output registers
// [RQ3] - a disabled edge acts as if it never happened; clock enable low runs
// [RQ4] - deselect with load starts nothing, yet operations in flight still finish
// [RQ5] - bus released two edges after a deselect or a write is started
// [RQ6] - one loaded address yields four consecutive data cycles
// [RQ7] - burst order input picks linear or interleaved sequence
// [RQ8] - load low with chip selected loads; high advances the running burst
// [RQ9] - load low while deselected ends any running burst
// [RQ10] - address inputs are ignored while advance is high
// [RQ11] - address captured only on enabled load edges with all selects true
// [RQ12] - read/write level sampled on the load edge sets access direction
// [RQ13] - output enable gates the data drivers without any clock
// [RQ14] - address, data and control are all registered on rising clock edges
// [RQ15] - reads and writes follow back to back with no idle cycle
// [RQ16] - array is 256K x 36 or 512K x 18 by variant
// [RQ17] - four byte selects write lanes independently; tie low for whole words
// [RQ18] - driver enable follows the pipeline so output enable may stay low
// [RQ19] - sleep input puts the device into a power-down state
// [RQ20] - order input high is interleaved, low linear; held static by controller
// [RQ21] - controller gives byte selects each write cycle; lanes written later
// [RQ22] - sleep gates the internal clock while stored data is retained
// [RQ23] - two selects are active low, one active high; any false deselects
// [RQ24] - counter steps low two bits; linear adds, interleaved xors
// [RQ25] - advance with no burst or after four words starts no access
module pzs_sram
(
  input  wire logic                                   clk_sys_i,
  input  wire logic                                   sys_rst_i,
  input  wire logic                                   clock_enable_n_i,
  input  wire logic                                   chip_select_a_n_i,
  input  wire logic                                   chip_select_b_i,
  input  wire logic                                   chip_select_c_n_i,
  input  wire logic                                   advance_or_load_i,
  input  wire logic                                   read_write_n_i,
  input  wire logic [pzs_pkg::ADDR_W-1:0]             word_address_i,
  input  wire logic [pzs_pkg::LANES-1:0]              byte_write_select_n_i,
  input  wire logic                                   burst_order_select_i,
  input  wire logic                                   output_enable_n_i,
  input  wire logic                                   sleep_request_i,
  input  wire logic [pzs_pkg::LANES*pzs_pkg::BYTE_W-1:0] data_lines_i,
  input  wire logic [pzs_pkg::LANES-1:0]              parity_data_lines_i,
  output logic      [pzs_pkg::LANES*pzs_pkg::BYTE_W-1:0] data_lines_o,
  output logic      [pzs_pkg::LANES-1:0]              parity_data_lines_o,
  output logic                                        data_lines_oe_o
);

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  // next offset inside the four-word group
  function automatic logic [pzs_pkg::BURST_W-1:0] burst_offset(
    input logic [pzs_pkg::BURST_W-1:0] start,
    input logic [pzs_pkg::BURST_W-1:0] step,
    input logic                        order
  );
    if (order == pzs_pkg::ORDER_INTERLEAVED)
    begin
      return start ^ step;                                   // [RQ24] [RQ20]
    end
    return start + step;                                     // [RQ24]
  endfunction

  // replace only the lanes whose select is low
  function automatic logic [pzs_pkg::DATA_W-1:0] lane_merge(
    input logic [pzs_pkg::DATA_W-1:0] old_word,
    input logic [pzs_pkg::DATA_W-1:0] new_word,
    input logic [pzs_pkg::LANES-1:0]  lane_n
  );
    logic [pzs_pkg::DATA_W-1:0] res;
    res = old_word;
    for (int k = 0; k < pzs_pkg::LANES; k++)
    begin
      if (!lane_n[k])
      begin
        res[k*pzs_pkg::LANE_W +: pzs_pkg::LANE_W] = new_word[k*pzs_pkg::LANE_W +: pzs_pkg::LANE_W]; // [RQ17]
      end
    end
    return res;
  endfunction

  // ----------------------------------------------------------------------
  // storage and state
  // ----------------------------------------------------------------------
  logic [pzs_pkg::DATA_W-1:0]   mem [pzs_pkg::MEM_WORDS];    // [RQ16]
  logic                         sleep_meta;
  logic                         sleep_sync;
  logic                         run;
  logic                         selected;
  logic                         load;
  pzs_pkg::pzs_burst_t          burst_st;
  logic [pzs_pkg::ADDR_W-1:0]   burst_base;
  logic [pzs_pkg::BURST_W-1:0]  burst_start;
  logic [pzs_pkg::BURST_W-1:0]  burst_cnt;
  logic                         burst_write;
  pzs_pkg::pzs_op_t             next_op;
  pzs_pkg::pzs_op_t             op_s1;
  pzs_pkg::pzs_op_t             op_s2;
  logic [pzs_pkg::DATA_W-1:0]   rd_data;
  logic [pzs_pkg::DATA_W-1:0]   fwd_word;
  logic [pzs_pkg::DATA_W-1:0]   bus_word;
  logic                         drive;
  pzs_pkg::pzs_wr_t             wbuf [pzs_pkg::BUF_DEPTH];
  logic [1:0]                   wbuf_cnt;
  logic                         wbuf_in_ready;
  logic                         wbuf_push;
  logic                         wbuf_pop;

  // ----------------------------------------------------------------------
  // clock gating and input decode
  // ----------------------------------------------------------------------
  // sleep is asynchronous, so it is synchronised before it gates anything
  always_ff @(posedge clk_sys_i)
  begin
    sleep_meta <= sleep_request_i;
    sleep_sync <= sleep_meta;
  end

  // a stalled edge is simply skipped; a full commit buffer also stalls
  assign run      = !clock_enable_n_i && !sleep_sync && wbuf_in_ready; // [RQ2] [RQ3] [RQ22] [RQ19]
  assign selected = !chip_select_a_n_i && chip_select_b_i && !chip_select_c_n_i; // [RQ23]
  assign load     = !advance_or_load_i;                      // [RQ8]

  // lane k of the internal word is {parity bit, data byte}
  always_comb
  begin
    bus_word = '0;
    for (int k = 0; k < pzs_pkg::LANES; k++)
    begin
      bus_word[k*pzs_pkg::LANE_W +: pzs_pkg::LANE_W] =
        {parity_data_lines_i[k], data_lines_i[k*pzs_pkg::BYTE_W +: pzs_pkg::BYTE_W]};
    end
  end

  // ----------------------------------------------------------------------
  // operation issue
  // ----------------------------------------------------------------------
  // new access from a load, or the next step of a running burst
  always_comb
  begin
    next_op = pzs_pkg::OP_IDLE;
    if (load && selected)
    begin
      next_op.valid  = 1'b1;                                 // [RQ8]
      next_op.write  = (read_write_n_i != pzs_pkg::RW_READ); // [RQ12]
      next_op.addr   = word_address_i;                       // [RQ11]
      next_op.lane_n = byte_write_select_n_i;                // [RQ21]
    end
    else if (!load && burst_st == pzs_pkg::BST_RUN && burst_cnt != pzs_pkg::BURST_LAST)
    begin
      // external address is not looked at here
      next_op.valid  = 1'b1;                                 // [RQ6] [RQ10]
      next_op.write  = burst_write;
      next_op.addr   = {burst_base[pzs_pkg::ADDR_W-1:pzs_pkg::BURST_W],
                        burst_offset(burst_start, burst_cnt + pzs_pkg::BURST_STEP,
                                     burst_order_select_i)}; // [RQ7] [RQ24]
      next_op.lane_n = byte_write_select_n_i;                // [RQ21]
    end
  end

  // ----------------------------------------------------------------------
  // burst counter
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      burst_st    <= pzs_pkg::BST_IDLE;
      burst_base  <= '0;
      burst_start <= pzs_pkg::BURST_FIRST;
      burst_cnt   <= pzs_pkg::BURST_FIRST;
      burst_write <= 1'b0;
    end
    else if (run)
    begin
      if (load && selected)
      begin
        burst_st    <= pzs_pkg::BST_RUN;                     // [RQ8]
        burst_base  <= word_address_i;                       // [RQ11]
        burst_start <= word_address_i[pzs_pkg::BURST_W-1:0];
        burst_cnt   <= pzs_pkg::BURST_FIRST;
        burst_write <= (read_write_n_i != pzs_pkg::RW_READ); // [RQ12]
      end
      else if (load)
      begin
        burst_st <= pzs_pkg::BST_IDLE;                       // [RQ9]
      end
      else if (burst_st == pzs_pkg::BST_RUN)
      begin
        if (burst_cnt != pzs_pkg::BURST_LAST)
        begin
          burst_cnt <= burst_cnt + pzs_pkg::BURST_STEP;      // [RQ6]
        end
        else
        begin
          burst_st <= pzs_pkg::BST_IDLE;                     // [RQ25]
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // two-stage pipeline
  // ----------------------------------------------------------------------
  // ops in flight advance on every enabled edge, so a deselect never cancels them
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      op_s1 <= pzs_pkg::OP_IDLE;
      op_s2 <= pzs_pkg::OP_IDLE;
    end
    else if (run)
    begin
      op_s1 <= next_op;                                      // [RQ14] [RQ4]
      op_s2 <= op_s1;                                        // [RQ1] [RQ15]
    end
  end

  // read data with pending writes folded in, oldest first, newest last
  always_comb
  begin
    fwd_word = mem[op_s1.addr];
    for (int i = 0; i < pzs_pkg::BUF_DEPTH; i++)
    begin
      if (i < int'(wbuf_cnt) && wbuf[i].addr == op_s1.addr)
      begin
        fwd_word = lane_merge(fwd_word, wbuf[i].data, wbuf[i].lane_n);
      end
    end
    if (op_s2.valid && op_s2.write && op_s2.addr == op_s1.addr)
    begin
      fwd_word = lane_merge(fwd_word, bus_word, op_s2.lane_n); // [RQ15]
    end
  end

  // output register and pipelined driver enable
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      rd_data <= '0;
      drive   <= 1'b0;
    end
    else if (run)
    begin
      drive <= op_s1.valid && !op_s1.write;                  // [RQ18] [RQ5] [RQ1]
      if (op_s1.valid && !op_s1.write)
      begin
        rd_data <= fwd_word;                                 // [RQ1]
      end
    end
  end

  // split the internal word back into data and parity pins
  always_comb
  begin
    data_lines_o        = '0;
    parity_data_lines_o = '0;
    for (int k = 0; k < pzs_pkg::LANES; k++)
    begin
      data_lines_o[k*pzs_pkg::BYTE_W +: pzs_pkg::BYTE_W] =
        rd_data[k*pzs_pkg::LANE_W +: pzs_pkg::BYTE_W];
      parity_data_lines_o[k] = rd_data[k*pzs_pkg::LANE_W + pzs_pkg::BYTE_W];
    end
  end

  // output enable is the one unclocked path into the driver
  assign data_lines_oe_o = drive && !output_enable_n_i;      // [RQ13]

  // ----------------------------------------------------------------------
  // write commit buffer
  // ----------------------------------------------------------------------
  // write data is caught on the bus edge and committed one edge later;
  // the array stops draining while asleep so its contents are retained
  assign wbuf_in_ready = (wbuf_cnt < 2'(pzs_pkg::BUF_DEPTH));
  assign wbuf_push     = run && op_s2.valid && op_s2.write;  // [RQ1] [RQ21]
  assign wbuf_pop      = !sleep_sync && (wbuf_cnt != pzs_pkg::CNT_ZERO); // [RQ22]

  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      wbuf_cnt <= pzs_pkg::CNT_ZERO;
      for (int i = 0; i < pzs_pkg::BUF_DEPTH; i++)
      begin
        wbuf[i] <= pzs_pkg::WR_IDLE;
      end
    end
    else
    begin
      for (int i = 0; i < pzs_pkg::BUF_DEPTH; i++)
      begin
        if (wbuf_pop && i + 1 < pzs_pkg::BUF_DEPTH)
        begin
          wbuf[i] <= wbuf[i+1];
        end
      end
      if (wbuf_push)
      begin
        wbuf[int'(wbuf_cnt) - (wbuf_pop ? 1 : 0)] <= '{addr: op_s2.addr, data: bus_word,
                                                        lane_n: op_s2.lane_n}; // [RQ17]
      end
      wbuf_cnt <= wbuf_cnt + 2'(wbuf_push) - 2'(wbuf_pop);
    end
  end

  // array write; reset does not touch the contents
  always_ff @(posedge clk_sys_i)
  begin
    if (!sys_rst_i && wbuf_pop)
    begin
      mem[wbuf[0].addr] <= lane_merge(mem[wbuf[0].addr], wbuf[0].data, wbuf[0].lane_n); // [RQ17]
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);

  a_read_latency: assert property ((run && load && selected && read_write_n_i) ##1 run
                                   |=> drive) // [RQ1]
    else $error("read data not driven two enabled edges after load");
  a_stall_freeze: assert property (!run |=> $stable(op_s1) && $stable(op_s2) && $stable(rd_data)
                                   && $stable(drive) && $stable(burst_cnt)) // [RQ2] [RQ3]
    else $error("state changed on a disabled edge");
  a_deselect_idle: assert property (run && load && !selected |=> !op_s1.valid
                                    && burst_st == pzs_pkg::BST_IDLE) // [RQ4] [RQ9]
    else $error("deselect started an access or kept a burst");
  a_write_release: assert property ((run && next_op.valid && next_op.write) ##1 run
                                    |=> !data_lines_oe_o) // [RQ5]
    else $error("bus driven two edges after a write start");
  a_burst_four: assert property ((run && load && selected) ##1 (run && !load)[*3]
                                 ##1 (run && !load) |=> !op_s1.valid) // [RQ6] [RQ25]
    else $error("burst did not stop after four words");
  a_linear_step: assert property (run && !load && burst_st == pzs_pkg::BST_RUN
                                  && burst_cnt != pzs_pkg::BURST_LAST && !burst_order_select_i
                                  |=> op_s1.addr[1:0] == $past(burst_start)
                                      + $past(burst_cnt) + 2'h1) // [RQ7] [RQ24]
    else $error("linear burst address wrong");
  a_inter_step: assert property (run && !load && burst_st == pzs_pkg::BST_RUN
                                 && burst_cnt != pzs_pkg::BURST_LAST && burst_order_select_i
                                 |=> op_s1.addr[1:0] == ($past(burst_start)
                                     ^ ($past(burst_cnt) + 2'h1))) // [RQ24] [RQ20]
    else $error("interleaved burst address wrong");
  a_addr_ignored: assert property (run && !load |=> !op_s1.valid
                                   || op_s1.addr[pzs_pkg::ADDR_W-1:2]
                                      == $past(burst_base[pzs_pkg::ADDR_W-1:2])) // [RQ10]
    else $error("external address used during advance");
  a_oe_gate: assert property (output_enable_n_i |-> !data_lines_oe_o) // [RQ13]
    else $error("driver on while output enable high");
  a_buf_bound: assert property (wbuf_cnt <= 2'(pzs_pkg::BUF_DEPTH)) // [RQ22]
    else $error("commit buffer overflow");

  c_write_read: cover property (run && load && selected && !read_write_n_i
                                ##1 run && load && selected && read_write_n_i);
  c_full_burst: cover property ((run && load && selected) ##1 (run && !load)[*3]);
  c_stall_mid: cover property (burst_st == pzs_pkg::BST_RUN && !run ##1 run && !load);
  c_forward: cover property (op_s2.valid && op_s2.write && op_s1.valid && !op_s1.write
                             && op_s1.addr == op_s2.addr && run);

endmodule

/* File: pzs_pkg.sv */
// package: constants and carriers of the pipelined zero-turnaround sram
package pzs_pkg;

  // ----------------------------------------------------------------------
  // organisation
  // ----------------------------------------------------------------------
  localparam bit WIDE_VARIANT = 1'b1;                 // 1: 256K x 36, 0: 512K x 18
  localparam int ADDR_W       = WIDE_VARIANT ? 18 : 19;
  localparam int LANES        = WIDE_VARIANT ? 4 : 2;
  localparam int BYTE_W       = 8;                    // data bits per lane
  localparam int LANE_W       = BYTE_W + 1;           // data plus parity bit
  localparam int DATA_W       = LANES * LANE_W;
  localparam int MEM_WORDS    = 2 ** ADDR_W;

  // ----------------------------------------------------------------------
  // pipeline and burst
  // ----------------------------------------------------------------------
  localparam int PIPE_LAT   = 2;                      // edges from address to data
  localparam int BURST_LEN  = 4;
  localparam int BURST_W    = 2;
  localparam int BUF_DEPTH  = 2;                      // write commit buffer entries
  localparam logic [BURST_W-1:0] BURST_FIRST = 2'h0;
  localparam logic [BURST_W-1:0] BURST_STEP  = 2'h1;
  localparam logic [BURST_W-1:0] BURST_LAST  = 2'h3;
  localparam logic ORDER_INTERLEAVED = 1'b1;
  localparam logic RW_READ           = 1'b1;

  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  typedef enum logic [0:0] {
    BST_IDLE = 1'b0,
    BST_RUN  = 1'b1
  } pzs_burst_t;

  typedef struct packed {
    logic              valid;
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [LANES-1:0]  lane_n;
  } pzs_op_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic [LANES-1:0]  lane_n;
  } pzs_wr_t;

  localparam pzs_op_t OP_IDLE = '0;
  localparam pzs_wr_t WR_IDLE = '0;
  localparam logic [1:0] CNT_ZERO = 2'h0;

endpackage

/* File: pzs_ctrl_model.sv */
// controller model: drives the sram bus, keeps a copy of the array, predicts reads
module pzs_ctrl_model
(
  input  wire logic                  clk_sys_i,
  output logic                       clock_enable_n_o,
  output logic                       chip_select_a_n_o,
  output logic                       chip_select_b_o,
  output logic                       chip_select_c_n_o,
  output logic                       advance_or_load_o,
  output logic                       read_write_n_o,
  output logic [pzs_pkg::ADDR_W-1:0] word_address_o,
  output logic [3:0]                 byte_write_select_n_o,
  output logic                       burst_order_select_o,
  output logic [31:0]                data_lines_o,
  output logic [3:0]                 parity_data_lines_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------------------------------------------------
  // model state
  // ----------------------------------------------------------------------
  logic [35:0]               mem [int];  // array copy, {parity, data}
  logic [35:0]               expq [$];   // read words still due on the bus
  logic [36:0]               wq [2];     // write data two counted edges ahead
  logic [pzs_pkg::ADDR_W-1:0] base;
  logic                      bwr;
  int                        cnt;
  int                        dsel;

  // idle bus at time zero, every select false
  initial
  begin
    {clock_enable_n_o, advance_or_load_o, burst_order_select_o} = 3'h0;
    {chip_select_a_n_o, chip_select_b_o, chip_select_c_n_o} = 3'h5;
    read_write_n_o = 1'b1;
    word_address_o = '0;
    byte_write_select_n_o = 4'hf;
    {parity_data_lines_o, data_lines_o} = 36'h0;
    wq = '{37'h0, 37'h0};
    cnt = 0;
    dsel = 0;
  end

  // ----------------------------------------------------------------------
  // one bus cycle: drive, let one edge pass, then move the write pipe
  // ----------------------------------------------------------------------
  task automatic cyc(input logic clock_enable_n, input logic adv, input logic rw, input logic sel,
                     input logic [pzs_pkg::ADDR_W-1:0] a, input logic [3:0] bw,
                     input logic [35:0] wd);
    logic [pzs_pkg::ADDR_W-1:0] wa;
    logic [35:0]                w;
    logic                       hit;
    hit = 1'b0;
    wa = a;
    clock_enable_n_o = clock_enable_n;
    advance_or_load_o = adv;
    read_write_n_o = rw;
    word_address_o = a;
    byte_write_select_n_o = bw;  // valid on every write cycle
    dsel = (dsel + 1) % 3;
    // each select takes its turn at deselecting
    chip_select_a_n_o = !sel && dsel == 0;
    chip_select_b_o = sel || dsel != 1;
    chip_select_c_n_o = !sel && dsel == 2;
    if (!clock_enable_n && !adv)
    begin
      cnt = sel ? 1 : 0;
      base = a;
      bwr = sel && rw != pzs_pkg::RW_READ;
      hit = sel;
    end
    else if (!clock_enable_n && cnt > 0 && cnt < 4)
    begin
      wa = base;
      wa[1:0] = burst_order_select_o ? base[1:0] ^ cnt[1:0] : base[1:0] + cnt[1:0];
      cnt++;
      hit = 1'b1;
    end
    if (hit && bwr)
    begin
      w = mem.exists(wa) ? mem[wa] : 36'h0;
      for (int k = 0; k < 4; k++)
        if (!bw[k])
        begin
          w[8*k +: 8] = wd[8*k +: 8];  // lanes written one by one
          w[32+k] = wd[32+k];
        end
      mem[wa] = w;
    end
    else if (hit)
      expq.push_back(mem[wa]);
    @(posedge clk_sys_i);
    #1;
    if (!clock_enable_n)
    begin
      wq[1] = wq[0];
      wq[0] = {hit && bwr, wd};  // data follows two counted edges later
    end
    // released lines show the inverse, never a stale copy
    {parity_data_lines_o, data_lines_o} = wq[1][36] ? wq[1][35:0]
                                          : ~{parity_data_lines_o, data_lines_o};
  endtask

endmodule

/* File: tb_pzs_sram.sv */
// testbench of the sram: scenarios, result checker and verdict
module tb_pzs_sram;
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------------
  logic                       clk_sys_i = 1'b0;
  logic                       sys_rst_i = 1'b1;
  logic                       output_enable_n_i = 1'b0;
  logic                       sleep_request_i = 1'b0;
  wire logic                  cen_n, csa_n, csb, csc_n, adv, rw_n, bos;
  wire logic [pzs_pkg::ADDR_W-1:0] addr;
  wire logic [3:0]            bw_n, pi, po;
  wire logic [31:0]           di, d_o;
  wire logic                  oe;
  logic [35:0]                r;
  logic [pzs_pkg::ADDR_W-1:0] a;
  logic                       stalls = 1'b0;
  int                         err_count = 0;
  int                         comparisons = 0;
  int                         seed = 7;

  always #50 clk_sys_i = ~clk_sys_i;

  pzs_ctrl_model ctrl (.clk_sys_i(clk_sys_i), .clock_enable_n_o(cen_n),
    .chip_select_a_n_o(csa_n), .chip_select_b_o(csb), .chip_select_c_n_o(csc_n),
    .advance_or_load_o(adv), .read_write_n_o(rw_n), .word_address_o(addr),
    .byte_write_select_n_o(bw_n), .burst_order_select_o(bos), .data_lines_o(di),
    .parity_data_lines_o(pi));

  pzs_sram dut (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .clock_enable_n_i(cen_n),
    .chip_select_a_n_i(csa_n), .chip_select_b_i(csb), .chip_select_c_n_i(csc_n),
    .advance_or_load_i(adv), .read_write_n_i(rw_n), .word_address_i(addr),
    .byte_write_select_n_i(bw_n), .burst_order_select_i(bos),
    .output_enable_n_i(output_enable_n_i), .sleep_request_i(sleep_request_i),
    .data_lines_i(di), .parity_data_lines_i(pi), .data_lines_o(d_o),
    .parity_data_lines_o(po), .data_lines_oe_o(oe));

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  task automatic conclude();
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [35:0] rnd();
    return 36'({$random(seed), $random(seed)});
  endfunction

  // one cycle, now and then behind a stall edge carrying junk
  task automatic op(input logic ad, input logic rw, input logic sel,
                    input logic [pzs_pkg::ADDR_W-1:0] ga, input logic [3:0] bw);
    logic [35:0] j;
    j = rnd();
    if (stalls && j[35:34] == 2'h0)
      ctrl.cyc(1'b1, j[0], j[1], j[2], j[pzs_pkg::ADDR_W-1:0], j[3:0], ~j);
    ctrl.cyc(1'b0, ad, rw, sel, ad ? j[pzs_pkg::ADDR_W-1:0] : ga, bw, rnd());
  endtask

  task automatic burst(input logic rw, input logic [pzs_pkg::ADDR_W-1:0] ga,
                       input logic [3:0] bw);
    op(1'b0, rw, 1'b1, ga, bw);
    repeat (3) op(1'b1, rw, 1'b1, ga, bw);
  endtask

  // every counted edge with the driver on hands over the oldest due word
  always @(posedge clk_sys_i)
    if (!sys_rst_i && cen_n === 1'b0 && oe === 1'b1)
    begin
      if (ctrl.expq.size() == 0)
        chk(36'h1, 36'h0);  // driver on with nothing due
      else
        chk({po, d_o}, ctrl.expq.pop_front());
    end

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  initial
  begin
    repeat (2) @(posedge clk_sys_i);
    #1 sys_rst_i = 1'b0;
    chk({35'h0, oe}, 36'h0);
    for (int ph = 0; ph < 2; ph++)
    begin
      ctrl.burst_order_select_o = ph[0];  // changed only while idle
      for (int g = 0; g < 8; g++)
      begin
        r = rnd();
        a = r[pzs_pkg::ADDR_W-1:0];
        stalls = g[0];
        burst(1'b0, a, 4'h0);
        burst(1'b0, a ^ 18'(r[21:20]), r[25:22]);
        burst(1'b1, a ^ 18'(r[27:26]), r[31:28]);
        op(1'b0, 1'b0, 1'b1, a, 4'h0);
        op(1'b0, 1'b1, 1'b1, a, r[3:0]);
      end
      repeat (3) op(1'b0, 1'b1, 1'b0, a, 4'h0);
      chk({35'h0, oe}, 36'h0);
    end
    stalls = 1'b0;
    // deselect in mid-burst: loaded words finish, advances then do nothing
    op(1'b0, 1'b1, 1'b1, a, 4'h0);
    op(1'b1, 1'b1, 1'b1, a, 4'h0);
    op(1'b0, 1'b1, 1'b0, a, 4'h0);
    repeat (2) op(1'b1, 1'b1, 1'b1, a, 4'h0);
    burst(1'b1, a, 4'h0);
    repeat (2) op(1'b1, 1'b1, 1'b1, a, 4'h0);
    repeat (3) op(1'b0, 1'b1, 1'b0, a, 4'h0);
    // output enable cuts the drivers at once, with no clock edge
    op(1'b0, 1'b1, 1'b1, a, 4'h0);
    op(1'b0, 1'b1, 1'b0, a, 4'h0);
    output_enable_n_i = 1'b1;
    #1 chk({35'h0, oe}, 36'h0);
    output_enable_n_i = 1'b0;
    #1 chk({35'h0, oe}, 36'h1);
    // gate the driver across one edge so the clocked check skips it; take the due word here
    output_enable_n_i = 1'b1;
    @(posedge clk_sys_i);
    chk({po, d_o}, ctrl.expq.pop_front());
    #1 output_enable_n_i = 1'b0;
    repeat (3) op(1'b0, 1'b1, 1'b0, a, 4'h0);
    // sleep while idle, then read the last group back
    sleep_request_i = 1'b1;
    repeat (6) op(1'b0, 1'b1, 1'b0, a, 4'h0);
    sleep_request_i = 1'b0;
    repeat (3) op(1'b0, 1'b1, 1'b0, a, 4'h0);
    burst(1'b1, a, 4'h0);
    repeat (3) op(1'b0, 1'b1, 1'b0, a, 4'h0);
    chk(36'(ctrl.expq.size()), 36'h0);
    conclude();
  end

endmodule
